/* File: src/ccr_charger_control_registers.sv */
// I2C-reached charger control registers and their decoded settings
`timescale 1ns/10ps
module ccr_charger_control_registers #(
   parameter logic [6:0] SLAVE_ADDR = ccr_pkg::SLAVE_ADDR
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic chargeEnablePinN,
   input wire logic watchdogExpired,
   input wire logic registerReset,
   input wire logic [4:0] inputCurrentLimit,
   output logic watchdogKick,
   output logic pulseSkipDisable,
   output logic boostActive,
   output logic chargeActive,
   output logic [ccr_pkg::MV_W-1:0] minSystemMv,
   output logic [ccr_pkg::MV_W-1:0] otgBatFallMv,
   output logic [ccr_pkg::MV_W-1:0] otgBatRiseMv,
   output logic [ccr_pkg::MV_W-1:0] boostLimitMa,
   output logic lowRdsFet,
   output logic [ccr_pkg::MV_W-1:0] chargeCurrentMa
);
   import ccr_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_REG, S_WDATA, S_RDATA, S_ACKOUT, S_ACKIN
   } ccr_state_e;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function automatic logic isDefined(input logic [7:0] addr);
      isDefined = (addr == ADDR_CTRL_ONE) || (addr == ADDR_CTRL_TWO);
   endfunction : isDefined

   function automatic logic [11:0] sysMinMv(input logic [2:0] code);
      logic [11:0] mv;
      mv = MIN_SYSTEM_VOLTAGE_BASE_MV;
      unique case (code)
         3'h0: mv = MIN_SYSTEM_VOLTAGE_BASE_MV;
         3'h1: mv = 12'haf0;
         3'h2: mv = 12'hbb8;
         3'h3: mv = 12'hc80;
         3'h4: mv = 12'hd48;
         3'h5: mv = 12'hdac;
         3'h6: mv = 12'he10;
         3'h7: mv = 12'he74;
      endcase
      sysMinMv = mv;
   endfunction : sysMinMv

   // ----------------------------------------
   // Pin synchronisation and edges
   // ----------------------------------------
   logic [2:0] pinSync;
   logic sclS, sdaS, cePinS;
   logic sclPrev_reg, sdaPrev_reg;

   ccr_sync2 #(.WIDTH(3), .INIT(3'h7)) pinSyncInst (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .asyncIn({chargeEnablePinN, sdaIn, sclIn}),
      .syncOut(pinSync)
   );
   assign sclS = pinSync[0];
   assign sdaS = pinSync[1];
   assign cePinS = pinSync[2];

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sclPrev_reg <= 1'b1;
         sdaPrev_reg <= 1'b1;
      end else begin
         sclPrev_reg <= sclS;
         sdaPrev_reg <= sdaS;
      end
   end

   logic sclRise, sclFall, startSeen, stopSeen;
   assign sclRise = sclS & ~sclPrev_reg;
   assign sclFall = ~sclS & sclPrev_reg;
   assign startSeen = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
   assign stopSeen = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;

   // ----------------------------------------
   // Serial protocol engine
   // ----------------------------------------
   ccr_state_e state_reg, after_reg;
   logic [2:0] bitCnt_reg;
   logic [7:0] rxShift_reg, txShift_reg, ptr_reg;
   logic ackGood_reg, ackStep_reg, hostAck_reg;
   logic [7:0] ctrlOne_reg, ctrlTwo_reg;
   logic [7:0] rxByte, readData;
   logic byteDone, wrEn;

   assign rxByte = {rxShift_reg[6:0], sdaS};
   assign byteDone = sclRise && (bitCnt_reg == 3'h7);
   assign readData = (ptr_reg == ADDR_CTRL_ONE) ? ctrlOne_reg :
                     (ptr_reg == ADDR_CTRL_TWO) ? ctrlTwo_reg : 8'h00;
   assign wrEn = (state_reg == S_WDATA) && byteDone && isDefined(ptr_reg);
   assign sdaOut = 1'b0;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= S_IDLE;
         after_reg <= S_IDLE;
         bitCnt_reg <= 3'h0;
         rxShift_reg <= 8'h00;
         txShift_reg <= 8'h00;
         ptr_reg <= 8'h00;
         ackGood_reg <= 1'b0;
         ackStep_reg <= 1'b0;
         hostAck_reg <= 1'b0;
         sdaOe <= 1'b0;
      end else if (stopSeen) begin
         state_reg <= S_IDLE;
         sdaOe <= 1'b0;
      end else if (startSeen) begin
         state_reg <= S_ADDR;
         bitCnt_reg <= 3'h0;
         sdaOe <= 1'b0;
      end else begin
         if (sclRise) begin
            rxShift_reg <= rxByte;
         end
         unique case (state_reg)
            S_IDLE: begin
               sdaOe <= 1'b0;
            end
            S_ADDR, S_REG, S_WDATA: begin
               if (sclRise) begin
                  bitCnt_reg <= bitCnt_reg + 3'h1;
               end
               if (byteDone) begin
                  state_reg <= S_ACKOUT;
                  ackStep_reg <= 1'b0;
                  if (state_reg == S_ADDR) begin
                     ackGood_reg <= (rxByte[7:1] == SLAVE_ADDR);
                     after_reg <= rxByte[0] ? S_RDATA : S_REG;
                  end else if (state_reg == S_REG) begin
                     ptr_reg <= rxByte;
                     ackGood_reg <= isDefined(rxByte);
                     after_reg <= S_WDATA;
                  end else begin
                     ackGood_reg <= isDefined(ptr_reg);
                     ptr_reg <= ptr_reg + 8'h01;
                     after_reg <= S_WDATA;
                  end
               end
            end
            S_ACKOUT: begin
               if (sclFall && !ackStep_reg) begin
                  sdaOe <= ackGood_reg;
                  ackStep_reg <= 1'b1;
               end else if (sclFall) begin
                  bitCnt_reg <= 3'h0;
                  if (!ackGood_reg) begin
                     sdaOe <= 1'b0;
                     state_reg <= S_IDLE;
                  end else if (after_reg == S_RDATA) begin
                     txShift_reg <= readData;
                     sdaOe <= ~readData[7];
                     state_reg <= S_RDATA;
                  end else begin
                     sdaOe <= 1'b0;
                     state_reg <= after_reg;
                  end
               end
            end
            S_RDATA: begin
               if (sclFall) begin
                  sdaOe <= ~txShift_reg[6];
                  txShift_reg <= {txShift_reg[6:0], 1'b0};
               end
               if (sclRise) begin
                  bitCnt_reg <= bitCnt_reg + 3'h1;
                  if (bitCnt_reg == 3'h7) begin
                     state_reg <= S_ACKIN;
                     ackStep_reg <= 1'b0;
                  end
               end
            end
            S_ACKIN: begin
               if (sclFall && !ackStep_reg) begin
                  sdaOe <= 1'b0;
                  ackStep_reg <= 1'b1;
               end else if (sclRise && ackStep_reg) begin
                  hostAck_reg <= ~sdaS;
                  if (!sdaS) begin
                     ptr_reg <= ptr_reg + 8'h01;
                  end
               end else if (sclFall) begin
                  bitCnt_reg <= 3'h0;
                  if (hostAck_reg) begin
                     txShift_reg <= readData;
                     sdaOe <= ~readData[7];
                     state_reg <= S_RDATA;
                  end else begin
                     state_reg <= S_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Register bank
   // ----------------------------------------
   logic [7:0] oneWrite, twoWrite, oneNext, twoNext;
   assign oneWrite = (wrEn && ptr_reg == ADDR_CTRL_ONE) ? rxByte : ctrlOne_reg;
   assign twoWrite = (wrEn && ptr_reg == ADDR_CTRL_TWO) ? rxByte : ctrlTwo_reg;
   assign oneNext = registerReset ? CTRL_ONE_RESET :
                    watchdogExpired ?
                    ((oneWrite & ~CTRL_ONE_WD_MASK) | (CTRL_ONE_RESET & CTRL_ONE_WD_MASK)) :
                    oneWrite;
   assign twoNext = registerReset ? CTRL_TWO_RESET :
                    watchdogExpired ?
                    ((twoWrite & ~CTRL_TWO_WD_MASK) | (CTRL_TWO_RESET & CTRL_TWO_WD_MASK)) :
                    twoWrite;

   logic kickWritten;
   assign kickWritten = wrEn && (ptr_reg == ADDR_CTRL_ONE) && rxByte[KICK_BIT];

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrlOne_reg <= CTRL_ONE_RESET;
         ctrlTwo_reg <= CTRL_TWO_RESET;
         watchdogKick <= 1'b0;
      end else begin
         // Kick bit set by a write, cleared by hardware the next cycle
         ctrlOne_reg <= kickWritten ? (oneNext | 8'h40) : (oneNext & 8'hbf);
         ctrlTwo_reg <= twoNext;
         watchdogKick <= kickWritten;
      end
   end

   // ----------------------------------------
   // Decoded settings
   // ----------------------------------------
   logic [5:0] ichgCode, ichgEff;
   logic [11:0] ilimMa, chgMaNext;
   logic boostEn, chargeNext, lowRdsNext;
   assign ichgCode = ctrlTwo_reg[FAST_CHARGE_CURRENT_LSB+5:FAST_CHARGE_CURRENT_LSB];
   assign ichgEff = (ichgCode > FAST_CHARGE_CURRENT_CLAMP_CODE) ? FAST_CHARGE_CURRENT_CLAMP_CODE : ichgCode;
   assign chgMaNext = 12'({6'h00, ichgEff} * FAST_CHARGE_CURRENT_STEP_MA);
   assign ilimMa = 12'(({7'h00, inputCurrentLimit} + 12'h001) * ILIM_STEP_MA);
   assign boostEn = ctrlOne_reg[BOOST_EN_BIT];
   assign chargeNext = !boostEn && ctrlOne_reg[CHARGE_EN_BIT] && !cePinS
                       && (ichgCode != 6'h00);
   assign lowRdsNext = boostEn || ctrlTwo_reg[FET_FULL_BIT]
                       || (ilimMa >= FET_SWITCH_MA);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pulseSkipDisable <= 1'b0;
         boostActive <= 1'b0;
         chargeActive <= 1'b0;
         minSystemMv <= MIN_SYSTEM_VOLTAGE_BASE_MV;
         otgBatFallMv <= OTG_FALL_HI_MV;
         otgBatRiseMv <= OTG_RISE_MV;
         boostLimitMa <= BOOST_HI_MA;
         lowRdsFet <= 1'b0;
         chargeCurrentMa <= 12'h000;
      end else begin
         pulseSkipDisable <= ctrlOne_reg[PULSE_SKIP_BIT];
         boostActive <= boostEn;
         chargeActive <= chargeNext;
         minSystemMv <= sysMinMv(ctrlOne_reg[MIN_SYSTEM_VOLTAGE_LSB+2:MIN_SYSTEM_VOLTAGE_LSB]);
         otgBatFallMv <= ctrlOne_reg[OTG_BAT_SEL_BIT] ? OTG_FALL_LO_MV : OTG_FALL_HI_MV;
         otgBatRiseMv <= OTG_RISE_MV;
         boostLimitMa <= ctrlTwo_reg[BOOST_CURRENT_LIMIT_BIT] ? BOOST_HI_MA : BOOST_LO_MA;
         lowRdsFet <= lowRdsNext;
         chargeCurrentMa <= chgMaNext;
      end
   end
endmodule : ccr_charger_control_registers

/* File: src/ccr_pkg.sv */
// Constants for the charger control register pair
// Contract
// - Kick bit restarts watchdog, then self-clears
// - Boost enable overrides charge enable
// - Charge needs pin low and bit set
// - Three-bit code selects minimum system voltage
// - Select bit sets OTG battery fall threshold; rise fixed at 3000 mV
// - Bit selects boost limit 0.5 or 1.2 A
// - FET sizing follows boost enable, bit and input limit
// - Charge current 60 mA per step, reset 2040
// - Codes above 110010 clamp to 3000 mA
// - Zero charge current code disables charging
// - Boost enable resets to zero
// - Charge enable bit resets to one
// - Undefined register address gets NACK, idle
package ccr_pkg;
   // ----------------------------------------
   // Bus and register map
   // ----------------------------------------
   localparam logic [6:0] SLAVE_ADDR = 7'h6b;
   localparam logic [7:0] ADDR_CTRL_ONE = 8'h01;
   localparam logic [7:0] ADDR_CTRL_TWO = 8'h02;
   localparam logic [7:0] CTRL_ONE_RESET = 8'h1a;
   localparam logic [7:0] CTRL_TWO_RESET = 8'ha2;
   // Fields watchdog expiry restores (1 = restored)
   localparam logic [7:0] CTRL_ONE_WD_MASK = 8'h70;
   localparam logic [7:0] CTRL_TWO_WD_MASK = 8'hbf;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int PULSE_SKIP_BIT = 7;
   localparam int KICK_BIT = 6;
   localparam int BOOST_EN_BIT = 5;
   localparam int CHARGE_EN_BIT = 4;
   localparam int MIN_SYSTEM_VOLTAGE_LSB = 1;
   localparam int OTG_BAT_SEL_BIT = 0;
   localparam int BOOST_CURRENT_LIMIT_BIT = 7;
   localparam int FET_FULL_BIT = 6;
   localparam int FAST_CHARGE_CURRENT_LSB = 0;
   // ----------------------------------------
   // Analog setting values
   // ----------------------------------------
   localparam int MV_W = 12;
   localparam logic [5:0] FAST_CHARGE_CURRENT_CLAMP_CODE = 6'h32;
   localparam logic [11:0] FAST_CHARGE_CURRENT_STEP_MA = 12'h03c;
   localparam logic [11:0] ILIM_STEP_MA = 12'h064;
   localparam logic [11:0] FET_SWITCH_MA = 12'h2bc;
   localparam logic [11:0] BOOST_LO_MA = 12'h1f4;
   localparam logic [11:0] BOOST_HI_MA = 12'h4b0;
   localparam logic [11:0] OTG_FALL_HI_MV = 12'haf0;
   localparam logic [11:0] OTG_FALL_LO_MV = 12'h9c4;
   localparam logic [11:0] OTG_RISE_MV = 12'hbb8;
   localparam logic [11:0] MIN_SYSTEM_VOLTAGE_BASE_MV = 12'ha28;
endpackage : ccr_pkg

/* File: src/ccr_sync2.sv */
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module ccr_sync2 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '1
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stageOne_reg;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         stageOne_reg <= INIT;
         syncOut <= INIT;
      end else begin
         stageOne_reg <= asyncIn;
         syncOut <= stageOne_reg;
      end
   end
endmodule : ccr_sync2

/* File: verif/ccr_monitor.sv */
// Property checker for the charger control register outputs
`timescale 1ns/10ps
module ccr_monitor (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic chargeEnablePinN,
   input wire logic [4:0] inputCurrentLimit,
   input wire logic watchdogKick,
   input wire logic boostActive,
   input wire logic chargeActive,
   input wire logic [ccr_pkg::MV_W-1:0] minSystemMv,
   input wire logic [ccr_pkg::MV_W-1:0] otgBatFallMv,
   input wire logic [ccr_pkg::MV_W-1:0] otgBatRiseMv,
   input wire logic lowRdsFet,
   input wire logic [ccr_pkg::MV_W-1:0] chargeCurrentMa
);
   import ccr_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   property p_kick; watchdogKick |=> !watchdogKick; endproperty
   a_kick: assert property (p_kick) else $error("kick too long");
   property p_boost; boostActive && $past(boostActive) |-> !chargeActive; endproperty
   a_boost: assert property (p_boost) else $error("charge in boost");
   property p_pin; chargeEnablePinN [*5] |-> !chargeActive; endproperty
   a_pin: assert property (p_pin) else $error("charge with pin high");
   property p_sysmin;
      !$past(sys_rst) |-> minSystemMv inside {12'ha28, 12'haf0, 12'hbb8, 12'hc80,
         12'hd48, 12'hdac, 12'he10, 12'he74};
   endproperty
   a_sysmin: assert property (p_sysmin) else $error("bad system minimum");
   property p_otg;
      !$past(sys_rst) |-> otgBatRiseMv == 12'hbb8 && otgBatFallMv inside {12'haf0, 12'h9c4};
   endproperty
   a_otg: assert property (p_otg) else $error("bad otg threshold");
   property p_fet; (inputCurrentLimit >= 5'h06) [*2] |-> lowRdsFet; endproperty
   a_fet: assert property (p_fet) else $error("small fet at high limit");
   property p_clamp;
      chargeCurrentMa <= 12'hbb8 && chargeCurrentMa % 12'h03c == 12'h000;
   endproperty
   a_clamp: assert property (p_clamp) else $error("bad charge current");
   property p_zero; chargeCurrentMa == 12'h000 |-> !chargeActive; endproperty
   a_zero: assert property (p_zero) else $error("charge at zero current");
endmodule : ccr_monitor

bind ccr_charger_control_registers ccr_monitor ccr_monitor_i (.clk_sys, .sys_rst,
   .chargeEnablePinN, .inputCurrentLimit, .watchdogKick, .boostActive, .chargeActive,
   .minSystemMv, .otgBatFallMv, .otgBatRiseMv, .lowRdsFet, .chargeCurrentMa);

/* File: verif/ccr_i2c_host.sv */
// Behavioural I2C host reaching the charger control registers
`timescale 1ns/10ps
module ccr_i2c_host (
   input wire logic clk_sys,
   input wire logic sdaOe,
   input wire logic sdaOut,
   output logic scl,
   output wire logic sda
);
   import ccr_pkg::*;
   logic drvLow = 1'h0;
   logic x;
   // Open-drain data line with pull-up
   assign sda = (sdaOe ? sdaOut : 1'h1) & !drvLow;
   initial scl = 1'h1;
   task automatic wt(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : wt
   task automatic pulse(input logic v, output logic s);
      wt(4);
      drvLow = !v;
      wt(4);
      scl = 1'h1;
      wt(8);
      s = sda;
      scl = 1'h0;
   endtask : pulse
   task automatic edges(input logic a, input logic b);
      wt(4);
      drvLow = a;
      wt(4);
      scl = 1'h1;
      wt(8);
      drvLow = b;
      wt(8);
   endtask : edges
   task automatic sendByte(input logic [7:0] b, output logic a);
      for (int i = 7; i >= 0; i--) pulse(b[i], x);
      pulse(1'h1, x);
      a = !x;
   endtask : sendByte
   task automatic wr(input logic [7:0] r, input logic [7:0] d, output logic [1:0] a);
      edges(1'h0, 1'h1);
      scl = 1'h0;
      sendByte({SLAVE_ADDR, 1'h0}, x);
      sendByte(r, a[1]);
      a[0] = 1'h0;
      if (a[1]) sendByte(d, a[0]);
      edges(1'h1, 1'h0);
   endtask : wr
   task automatic rd(input logic [7:0] r, input int n, output logic [15:0] d);
      d = 16'h0000;
      edges(1'h0, 1'h1);
      scl = 1'h0;
      sendByte({SLAVE_ADDR, 1'h0}, x);
      sendByte(r, x);
      edges(1'h0, 1'h1);
      scl = 1'h0;
      sendByte({SLAVE_ADDR, 1'h1}, x);
      for (int i = 8 * n - 1; i >= 0; i--) begin
         pulse(1'h1, d[i]);
         if (i % 8 == 0 && i > 0) pulse(1'h0, x);
      end
      pulse(1'h1, x);
      edges(1'h1, 1'h0);
   endtask : rd
endmodule : ccr_i2c_host

/* File: verif/testbench.sv */
// Self-checking bench for the charger control registers
`timescale 1ns/10ps
module testbench;
   import ccr_pkg::*;
   typedef struct {logic [7:0] r, d; logic pn; logic [4:0] il; logic [11:0] cur, lim;
      logic [2:0] fl;} ccr_row_s;
   logic clk_sys = 1'h0;
   logic sys_rst = 1'h1;
   logic pinN = 1'h0;
   logic wdExp = 1'h0;
   logic regRst = 1'h0;
   logic [4:0] il = 5'h00;
   logic scl, sda, sdaOut, sdaOe, kick, pfm, bst, chg, fet;
   logic [11:0] sysMv, fallMv, riseMv, limMa, curMa;
   logic [15:0] rb;
   logic [1:0] ack;
   int errors = 0;
   int checks_done = 0;
   int kicks = 0;
   logic [11:0] mv[8] = '{12'ha28, 12'haf0, 12'hbb8, 12'hc80, 12'hd48, 12'hdac, 12'he10,
      12'he74};
   ccr_row_s rows[7] = '{'{8'h02, 8'h01, 1'h0, 5'h05, 12'h03c, 12'h1f4, 3'h2},
      '{8'h02, 8'hb2, 1'h0, 5'h05, 12'hbb8, 12'h4b0, 3'h2},
      '{8'h02, 8'h3f, 1'h0, 5'h06, 12'hbb8, 12'h1f4, 3'h6},
      '{8'h02, 8'h40, 1'h0, 5'h00, 12'h000, 12'h1f4, 3'h4},
      '{8'h02, 8'h33, 1'h1, 5'h00, 12'hbb8, 12'h1f4, 3'h0},
      '{8'h01, 8'h0a, 1'h0, 5'h00, 12'hbb8, 12'h1f4, 3'h0},
      '{8'h01, 8'h3b, 1'h0, 5'h00, 12'hbb8, 12'h1f4, 3'h5}};
   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (kick === 1'h1) kicks <= kicks + 1;
   ccr_i2c_host ccr_i2c_host_i (.clk_sys(clk_sys), .sdaOe(sdaOe), .sdaOut(sdaOut), .scl(scl),
      .sda(sda));
   ccr_charger_control_registers ccr_charger_control_registers_i (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .chargeEnablePinN(pinN), .watchdogExpired(wdExp), .registerReset(regRst),
      .inputCurrentLimit(il), .watchdogKick(kick), .pulseSkipDisable(pfm), .boostActive(bst),
      .chargeActive(chg), .minSystemMv(sysMv), .otgBatFallMv(fallMv), .otgBatRiseMv(riseMv),
      .boostLimitMa(limMa), .lowRdsFet(fet), .chargeCurrentMa(curMa));
   task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] r, input logic [7:0] e);
      ccr_i2c_host_i.rd(r, 1, rb);
      chk("reg", {4'h0, e}, {4'h0, rb[7:0]});
   endtask : rdc
   task automatic wr(input logic [7:0] r, input logic [7:0] d);
      ccr_i2c_host_i.wr(r, d, ack);
      repeat (6) @(negedge clk_sys);
   endtask : wr
   task automatic wrap_up;
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (2) @(negedge clk_sys);
      sys_rst = 1'h0;
      repeat (4) @(negedge clk_sys);
      rdc(ADDR_CTRL_ONE, 8'h1a);
      rdc(ADDR_CTRL_TWO, 8'ha2);
      chk("sysMv", 12'hdac, sysMv);
      chk("fallMv", 12'haf0, fallMv);
      chk("riseMv", 12'hbb8, riseMv);
      chk("curMa", 12'h7f8, curMa);
      chk("limMa", 12'h4b0, limMa);
      chk("flags", 12'h002, {9'h000, fet, chg, bst});
      foreach (rows[i]) begin
         pinN = rows[i].pn;
         il = rows[i].il;
         wr(rows[i].r, rows[i].d);
         rdc(rows[i].r, rows[i].d);
         chk("curMa", rows[i].cur, curMa);
         chk("limMa", rows[i].lim, limMa);
         chk("flags", {9'h000, rows[i].fl}, {9'h000, fet, chg, bst});
      end
      chk("fallMv", 12'h9c4, fallMv);
      for (int c = 0; c < 8; c++) begin
         wr(8'h01, {4'h1, c[2:0], 1'h0});
         chk("sysMv", mv[c], sysMv);
      end
      kicks = 0;
      wr(8'h01, 8'h5a);
      chk("kicks", 12'h001, kicks[11:0]);
      rdc(8'h01, 8'h1a);
      wr(8'h03, 8'h55);
      chk("ack", 12'h000, {10'h000, ack});
      wr(8'h01, 8'haf);
      chk("ack", 12'h003, {10'h000, ack});
      wr(8'h02, 8'h41);
      @(negedge clk_sys) wdExp = 1'h1;
      @(negedge clk_sys) wdExp = 1'h0;
      rdc(8'h01, 8'h9f);
      rdc(8'h02, 8'he2);
      chk("pfm", 12'h001, {11'h000, pfm});
      @(negedge clk_sys) regRst = 1'h1;
      @(negedge clk_sys) regRst = 1'h0;
      rdc(8'h01, 8'h1a);
      rdc(8'h02, 8'ha2);
      // Mid-run system reset, then a two-byte read
      wr(8'h01, 8'h3b);
      wr(8'h02, 8'h41);
      @(negedge clk_sys) sys_rst = 1'h1;
      repeat (2) @(negedge clk_sys);
      sys_rst = 1'h0;
      repeat (4) @(negedge clk_sys);
      chk("flags", 12'h002, {9'h000, fet, chg, bst});
      chk("curMa", 12'h7f8, curMa);
      ccr_i2c_host_i.rd(8'h01, 2, rb);
      chk("pair1", 12'h01a, {4'h0, rb[15:8]});
      chk("pair2", 12'h0a2, {4'h0, rb[7:0]});
      wrap_up();
   end
   initial begin
      // Full sequence needs about 0.8 ms
      #2000000;
      errors++;
      wrap_up();
   end
endmodule : testbench
